// ==== rtl/monitor_pkg.sv ====
package monitor_pkg;

  // ************************************************************
  // Register indices; byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_RUN_STATUS = 6'h10;
  localparam logic [5:0] IDX_PANEL_STATUS = 6'h11;
  localparam logic [5:0] IDX_SETTING_FAULT = 6'h12;
  localparam logic [5:0] IDX_UNUSED_WORD = 6'h13;
  localparam logic [5:0] IDX_FAULT_ONE = 6'h14;
  localparam logic [5:0] IDX_FAULT_TWO = 6'h15;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

  localparam int ADDR_W = 8;
  localparam int IRQ_W = 5;

  // ************************************************************
  // Interrupt event positions
  // ************************************************************
  localparam int EV_MAJOR = 0;
  localparam int EV_MINOR = 1;
  localparam int EV_FAULT_ONE = 2;
  localparam int EV_FAULT_TWO = 3;
  localparam int EV_SETTING = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // ************************************************************
  // Word layouts, msb first
  // ************************************************************
  typedef struct packed {
    logic run_command_source_flag;
    logic speed_source_flag;
    logic [5:0] unused;
    logic major_fault;
    logic minor_fault;
    logic ready;
    logic speed_agree;
    logic reset_active;
    logic reverse;
    logic zero_speed;
    logic running;
  } run_word_t;

  typedef struct packed {
    logic [11:0] unused;
    logic pc_connected;
    logic programming_mode;
    logic fault_active;
    logic setting_fault;
  } panel_word_t;

  typedef struct packed {
    logic brake_resistor_hot;
    logic brake_switch_failure;
    logic torque_excess_2;
    logic torque_excess_1;
    logic drive_thermal_overload;
    logic motor_thermal_overload;
    logic heatsink_trip;
    logic heatsink_warm_warning;
    logic dc_link_high_voltage;
    logic output_current_trip;
    logic earth_leak;
    logic unused;
    logic low_voltage_trip_c;
    logic low_voltage_trip_b;
    logic low_voltage_trip_a;
    logic dc_fuse_open;
  } fault_one_t;

  typedef struct packed {
    logic unused_hi;
    logic nvm_error;
    logic keypad_removed;
    logic motor_temp_warning;
    logic output_phase_missing;
    logic input_phase_missing;
    logic encoder_lost;
    logic speed_mismatch;
    logic speed_excess;
    logic [1:0] unused_lo;
    logic external_trip_input_7;
    logic external_trip_input_6;
    logic external_trip_input_5;
    logic external_trip_input_4;
    logic external_trip_input_3;
  } fault_two_t;

  typedef struct packed {
    run_word_t run;
    panel_word_t panel;
    logic [15:0] setting_fault_number;
    fault_one_t fault_one;
    fault_two_t fault_two;
  } monitor_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avalon_req_t;

endpackage : monitor_pkg

// ==== rtl/drive_monitor_status_registers.sv ====
`timescale 1ns/10ps
module drive_monitor_status_registers (
  input wire logic clk,
  input wire logic rst,
  input wire monitor_pkg::monitor_t mon_in,
  input wire monitor_pkg::avalon_req_t av,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    monitor_pkg::monitor_t mon;
    logic [monitor_pkg::IRQ_W-1:0] irq_status;
    logic [monitor_pkg::IRQ_W-1:0] irq_mask;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
  } state_t;

  localparam state_t RESET_STATE = '{
    mon: '0,
    irq_status: '0,
    irq_mask: monitor_pkg::IRQ_MASK_RESET,
    waitrequest: 1'b1,
    readdata: 32'h0000_0000,
    irq: 1'b0
  };

  state_t state_ff;
  state_t nxt_state;
  monitor_pkg::monitor_t clean;
  logic [5:0] idx;
  logic req;
  logic done;
  logic [15:0] rd_word;
  logic [monitor_pkg::IRQ_W-1:0] events;
  logic [monitor_pkg::IRQ_W-1:0] w1c;

  assign idx = av.address[7:2];
  assign req = av.read | av.write;
  // Completion edge: master samples waitrequest low here
  assign done = req & ~state_ff.waitrequest;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    clean = mon_in;
    clean.run.unused = '0;
    clean.panel.unused = '0;
    clean.fault_one.unused = 1'b0;
    clean.fault_two.unused_lo = '0;
    clean.fault_two.unused_hi = 1'b0;
    nxt_state.mon = clean;

    // Edges are taken against the previous snapshot, so a fault held
    // active raises one event only
    events = '0;
    events[monitor_pkg::EV_MAJOR] = clean.run.major_fault & ~state_ff.mon.run.major_fault;
    events[monitor_pkg::EV_MINOR] = clean.run.minor_fault & ~state_ff.mon.run.minor_fault;
    events[monitor_pkg::EV_FAULT_ONE] = |(clean.fault_one & ~state_ff.mon.fault_one);
    events[monitor_pkg::EV_FAULT_TWO] = |(clean.fault_two & ~state_ff.mon.fault_two);
    events[monitor_pkg::EV_SETTING] =
      clean.panel.setting_fault & ~state_ff.mon.panel.setting_fault;

    case (idx)
      monitor_pkg::IDX_RUN_STATUS: rd_word = state_ff.mon.run;
      monitor_pkg::IDX_PANEL_STATUS: rd_word = state_ff.mon.panel;
      monitor_pkg::IDX_SETTING_FAULT: rd_word = state_ff.mon.setting_fault_number;
      monitor_pkg::IDX_UNUSED_WORD: rd_word = 16'h0000;
      monitor_pkg::IDX_FAULT_ONE: rd_word = state_ff.mon.fault_one;
      monitor_pkg::IDX_FAULT_TWO: rd_word = state_ff.mon.fault_two;
      monitor_pkg::IDX_IRQ_STATUS: rd_word = {11'h000, state_ff.irq_status};
      monitor_pkg::IDX_IRQ_MASK: rd_word = {11'h000, state_ff.irq_mask};
      default: rd_word = 16'h0000;
    endcase

    // One wait cycle per access keeps read data straight from a flop
    if (req && state_ff.waitrequest) begin
      nxt_state.waitrequest = 1'b0;
      nxt_state.readdata = av.read ? {16'h0000, rd_word} : 32'h0000_0000;
    end else begin
      nxt_state.waitrequest = 1'b1;
    end

    // Only the interrupt words accept writes; monitor words drop them
    w1c = '0;
    if (done && av.write && av.byteenable[0]) begin
      case (idx)
        monitor_pkg::IDX_IRQ_STATUS: w1c = av.writedata[monitor_pkg::IRQ_W-1:0];
        monitor_pkg::IDX_IRQ_MASK: nxt_state.irq_mask = av.writedata[monitor_pkg::IRQ_W-1:0];
        default: w1c = '0;
      endcase
    end
    // Set wins over a clear in the same cycle
    nxt_state.irq_status = (state_ff.irq_status & ~w1c) | events;
    nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= RESET_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign readdata = state_ff.readdata;
  assign waitrequest = state_ff.waitrequest;
  assign irq = state_ff.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic first_cyc;
  logic is_mon;
  assign first_cyc = req & state_ff.waitrequest;
  assign is_mon = (idx >= monitor_pkg::IDX_RUN_STATUS) && (idx <= monitor_pkg::IDX_FAULT_TWO);

  // Field checks compare read data with the pin levels two edges back, at the
  // bit positions software expects, so a slip in the word layouts shows up
  monitor_pkg::run_word_t run_in;
  monitor_pkg::panel_word_t pnl_in;
  monitor_pkg::fault_one_t f1_in;
  monitor_pkg::fault_two_t f2_in;
  logic rd_run;
  logic rd_pnl;
  logic rd_set;
  logic rd_one;
  logic rd_two;
  assign run_in = mon_in.run;
  assign pnl_in = mon_in.panel;
  assign f1_in = mon_in.fault_one;
  assign f2_in = mon_in.fault_two;
  assign rd_run = first_cyc & av.read & (idx == monitor_pkg::IDX_RUN_STATUS);
  assign rd_pnl = first_cyc & av.read & (idx == monitor_pkg::IDX_PANEL_STATUS);
  assign rd_set = first_cyc & av.read & (idx == monitor_pkg::IDX_SETTING_FAULT);
  assign rd_one = first_cyc & av.read & (idx == monitor_pkg::IDX_FAULT_ONE);
  assign rd_two = first_cyc & av.read & (idx == monitor_pkg::IDX_FAULT_TWO);

  read_only_a: assert property (
    (done && av.write && is_mon) |=>
      (state_ff.irq_mask == $past(state_ff.irq_mask)) &&
      ((state_ff.irq_status & ~$past(state_ff.irq_status)) == $past(events))
  ) else $error("write to monitor word changed writable state");

  run_word_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_RUN_STATUS) |=>
      (readdata[13:8] == 6'h00) && (readdata[7:0] == $past(mon_in.run[7:0], 2)) &&
      (readdata[15:14] == $past(state_ff.mon.run[15:14]))
  ) else $error("run status word read wrong");

  panel_word_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_PANEL_STATUS) |=>
      (readdata[31:4] == 28'h0) && (readdata[3:0] == $past(state_ff.mon.panel[3:0]))
  ) else $error("panel status word read wrong");

  panel_prog_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_PANEL_STATUS) ##1
      $past(state_ff.mon.panel.programming_mode) |-> readdata[2]
  ) else $error("programming mode bit not shown");

  fault_one_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_FAULT_ONE) |=>
      !readdata[4] && (readdata[15:5] == $past(state_ff.mon.fault_one[15:5])) &&
      (readdata[3:0] == $past(state_ff.mon.fault_one[3:0]))
  ) else $error("fault word one read wrong");

  fault_two_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_FAULT_TWO) |=>
      (readdata[6:5] == 2'b00) && !readdata[15] &&
      (readdata[14:7] == $past(state_ff.mon.fault_two[14:7])) &&
      (readdata[4:0] == $past(state_ff.mon.fault_two[4:0]))
  ) else $error("fault word two read wrong");

  unused_word_a: assert property (
    (first_cyc && av.read && idx == monitor_pkg::IDX_UNUSED_WORD) |=> readdata == 32'h0
  ) else $error("unused word not zero");

  snapshot_zero_a: assert property (
    ##1 (state_ff.mon.run.unused == 6'h00) && !state_ff.mon.fault_one.unused &&
      (state_ff.mon.fault_two.unused_lo == 2'b00) && !state_ff.mon.fault_two.unused_hi &&
      (state_ff.mon.panel.unused == 12'h000)
  ) else $error("unused monitor bits not zero");

  run_source_a: assert property (
    rd_run |=> readdata[15:14] ==
      $past({run_in.run_command_source_flag, run_in.speed_source_flag}, 2)
  ) else $error("source flags misplaced in run status");

  panel_bits_a: assert property (
    rd_pnl |=> (readdata[3] == $past(pnl_in.pc_connected, 2)) &&
      (readdata[1:0] == $past({pnl_in.fault_active, pnl_in.setting_fault}, 2))
  ) else $error("panel fault or link bits misplaced");

  setting_num_a: assert property (
    rd_set |=> readdata == {16'h0000, $past(mon_in.setting_fault_number, 2)}
  ) else $error("setting fault number read wrong");

  fuse_uv_a: assert property (
    rd_one |=> (readdata[0] == $past(f1_in.dc_fuse_open, 2)) &&
      (readdata[3:1] == $past({f1_in.low_voltage_trip_c, f1_in.low_voltage_trip_b,
        f1_in.low_voltage_trip_a}, 2))
  ) else $error("fuse or undervoltage bits misplaced");

  trip_bits_a: assert property (
    rd_one |=> readdata[7:5] ==
      $past({f1_in.dc_link_high_voltage, f1_in.output_current_trip, f1_in.earth_leak}, 2)
  ) else $error("earth, current or overvoltage bits misplaced");

  heatsink_bits_a: assert property (
    rd_one |=> readdata[9:8] ==
      $past({f1_in.heatsink_trip, f1_in.heatsink_warm_warning}, 2)
  ) else $error("heatsink bits misplaced");

  overload_bits_a: assert property (
    rd_one |=> readdata[13:10] == $past({f1_in.torque_excess_2, f1_in.torque_excess_1,
      f1_in.drive_thermal_overload, f1_in.motor_thermal_overload}, 2)
  ) else $error("overload or overtorque bits misplaced");

  brake_bits_a: assert property (
    rd_one |=> readdata[15:14] ==
      $past({f1_in.brake_resistor_hot, f1_in.brake_switch_failure}, 2)
  ) else $error("braking bits misplaced");

  ext_inputs_a: assert property (
    rd_two |=> readdata[4:0] == $past({f2_in.external_trip_input_7,
      f2_in.external_trip_input_6, f2_in.external_trip_input_5,
      f2_in.external_trip_input_4, f2_in.external_trip_input_3}, 2)
  ) else $error("external trip inputs out of order");

  speed_bits_a: assert property (
    rd_two |=> readdata[9:7] ==
      $past({f2_in.encoder_lost, f2_in.speed_mismatch, f2_in.speed_excess}, 2)
  ) else $error("speed or encoder bits misplaced");

  phase_bits_a: assert property (
    rd_two |=> readdata[11:10] ==
      $past({f2_in.output_phase_missing, f2_in.input_phase_missing}, 2)
  ) else $error("phase loss bits misplaced");

  motor_temp_a: assert property (
    rd_two |=> readdata[12] == $past(f2_in.motor_temp_warning, 2)
  ) else $error("motor temperature bit misplaced");

  keypad_nvm_a: assert property (
    rd_two |=> (readdata[14:13] == $past({f2_in.nvm_error, f2_in.keypad_removed}, 2)) &&
      !readdata[15]
  ) else $error("keypad or memory bit misplaced");

  wait_one_a: assert property (
    first_cyc |=> !waitrequest ##1 waitrequest
  ) else $error("access not answered after one wait cycle");

  sticky_a: assert property (
    (state_ff.irq_status[monitor_pkg::EV_MAJOR] && !w1c[monitor_pkg::EV_MAJOR]) |=>
      state_ff.irq_status[monitor_pkg::EV_MAJOR]
  ) else $error("status bit lost without clear");

  irq_level_a: assert property (
    (events[monitor_pkg::EV_MAJOR] && state_ff.irq_mask[monitor_pkg::EV_MAJOR] &&
      !(done && av.write && idx == monitor_pkg::IDX_IRQ_MASK)) |=> irq
  ) else $error("unmasked event did not raise irq");

  irq_quiet_a: assert property (
    !(|(state_ff.irq_status & state_ff.irq_mask)) |-> !irq
  ) else $error("irq high with no unmasked status bit");

  upper_zero_a: assert property (
    readdata[31:16] == 16'h0000
  ) else $error("upper read lanes not zero");

  read_hold_a: assert property (
    !first_cyc |=> $stable(readdata)
  ) else $error("read data moved between accesses");

  mask_write_a: assert property (
    (done && av.write && av.byteenable[0] && idx == monitor_pkg::IDX_IRQ_MASK) |=>
      state_ff.irq_mask == $past(av.writedata[monitor_pkg::IRQ_W-1:0])
  ) else $error("mask write did not land");

  // Reset itself is checked, so this one must not be disabled by it
  reset_values_a: assert property (disable iff (1'b0)
    rst |=> waitrequest && !irq && (readdata == 32'h0000_0000) &&
      (state_ff.irq_mask == monitor_pkg::IRQ_MASK_RESET) && (state_ff.irq_status == '0)
  ) else $error("reset did not restore the idle state");

  major_event_a: assert property (
    $rose(state_ff.mon.run.major_fault) |-> state_ff.irq_status[monitor_pkg::EV_MAJOR]
  ) else $error("major fault did not set its status bit");

  minor_event_a: assert property (
    $rose(state_ff.mon.run.minor_fault) |-> state_ff.irq_status[monitor_pkg::EV_MINOR]
  ) else $error("minor fault did not set its status bit");

  setting_event_a: assert property (
    $rose(state_ff.mon.panel.setting_fault) |-> state_ff.irq_status[monitor_pkg::EV_SETTING]
  ) else $error("setting fault did not set its status bit");

  fault_one_event_a: assert property (
    (|(state_ff.mon.fault_one & ~$past(state_ff.mon.fault_one))) |->
      state_ff.irq_status[monitor_pkg::EV_FAULT_ONE]
  ) else $error("new fault one bit did not set its status bit");

  fault_two_event_a: assert property (
    (|(state_ff.mon.fault_two & ~$past(state_ff.mon.fault_two))) |->
      state_ff.irq_status[monitor_pkg::EV_FAULT_TWO]
  ) else $error("new fault two bit did not set its status bit");

  // ************************************************************
  // Per-bit interrupt checks
  // ************************************************************
  for (genvar g = 0; g < monitor_pkg::IRQ_W; g++) begin : g_irq_bit
    status_hold_a: assert property (
      (state_ff.irq_status[g] && !w1c[g]) |=> state_ff.irq_status[g]
    ) else $error("status bit lost without clear");

    set_wins_a: assert property (
      events[g] |=> state_ff.irq_status[g]
    ) else $error("event lost against a clear");

    clear_one_a: assert property (
      (w1c[g] && !events[g]) |=> !state_ff.irq_status[g]
    ) else $error("status bit not cleared by a one");

    irq_bit_a: assert property (
      (state_ff.irq_status[g] && state_ff.irq_mask[g]) |-> irq
    ) else $error("unmasked status bit without irq");
  end

  read_cov_c: cover property (first_cyc && av.read && idx == monitor_pkg::IDX_FAULT_ONE ##1 done);
  write_mon_c: cover property (done && av.write && is_mon);
  irq_clear_c: cover property (irq ##[1:20] !irq);
  set_clear_c: cover property (|(events & w1c));

endmodule : drive_monitor_status_registers

// ==== verification/monitor_master.sv ====
`timescale 1ns/10ps
// ****************
// Link master model
// ****************
module monitor_master (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output monitor_pkg::avalon_req_t av
);
  initial av = '0;

  // Holds the request until waitrequest is sampled low or 64 edges pass; writes go out only on command
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output bit hung);
    int n;
    n = 0;
    av <= '{address: addr, read: !wr, write: wr, writedata: wd, byteenable: 4'hf};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    rd = readdata;
    hung = (waitrequest !== 1'b0);
    av <= '0;
    // One idle edge keeps two assignments of av out of one time step
    @(posedge clk);
  endtask : access
endmodule : monitor_master

// ==== verification/tb_drive_monitor_status_registers.sv ====
`timescale 1ns/10ps
module tb_drive_monitor_status_registers;
  logic clk = 1'b0;
  logic rst = 1'b1;
  monitor_pkg::monitor_t mon_in = '0;
  monitor_pkg::avalon_req_t av;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  logic [15:0] used [6] = '{16'hc0ff, 16'h000f, 16'hffff, 16'h0000, 16'hffef, 16'h7f9f};
  logic [79:0] ev [5] = '{80'h80 << 64, 80'h40 << 64, 80'h1 << 16, 80'h1, 80'h1 << 48};

  always #2.5 clk = ~clk;

  drive_monitor_status_registers u_drive_monitor_status_registers (
    .clk(clk), .rst(rst), .mon_in(mon_in), .av(av),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  monitor_master u_monitor_master (
    .clk(clk), .waitrequest(waitrequest), .readdata(readdata), .av(av));

  // ****************
  // Shared tasks
  // ****************
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    bit hung;
    u_monitor_master.access(wr, a, wd, rd, hung);
    if (hung) begin
      err_count++;
      report_and_stop();
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask : rd_chk

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] d;
    monitor_pkg::monitor_t m;
    int w;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(8'hc0, 32'h0);
    rd_chk(8'hc4, 32'h0);
    check(32'(irq), 32'h0);
    $display("test reset done");
    // All inputs are driven to ones while word 3 is read, so that any leak into it shows
    for (int k = 0; k < 6; k++) begin
      for (int b = 0; b < 16; b++) begin
        w = (k < 3) ? k : k - 1;
        mon_in <= (k == 3) ? '1 : 80'h1 << (16 * (4 - w) + b);
        repeat (3) @(posedge clk);
        rd_chk(8'h40 + 8'(4 * k), 32'(used[k] & (16'h1 << b)));
      end
    end
    $display("test bit walk done");
    m = '0;
    m.run.major_fault = 1'b1;
    m.panel.pc_connected = 1'b1;
    m.fault_one.heatsink_trip = 1'b1;
    m.fault_two.nvm_error = 1'b1;
    mon_in <= m;
    repeat (3) @(posedge clk);
    rd_chk(8'h40, 32'h0080);
    rd_chk(8'h44, 32'h0008);
    rd_chk(8'h50, 32'h0200);
    rd_chk(8'h54, 32'h4000);
    $display("test named fields done");
    mon_in <= '1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 8'h40 + 8'(4 * k), 32'h0, d);
      rd_chk(8'h40 + 8'(4 * k), 32'(used[k]));
    end
    bus(1'b1, 8'h80, 32'hffff_ffff, d);
    rd_chk(8'h80, 32'h0);
    $display("test write ignored done");
    bus(1'b1, 8'hc4, 32'h1f, d);
    rd_chk(8'hc4, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      mon_in <= '0;
      repeat (3) @(posedge clk);
      bus(1'b1, 8'hc0, 32'h1f, d);
      rd_chk(8'hc0, 32'h0);
      check(32'(irq), 32'h0);
      mon_in <= ev[i];
      repeat (3) @(posedge clk);
      rd_chk(8'hc0, 32'h1 << i);
      check(32'(irq), 32'h1);
      bus(1'b1, 8'hc4, ~(32'h1 << i) & 32'h1f, d);
      @(posedge clk);
      check(32'(irq), 32'h0);
      bus(1'b1, 8'hc4, 32'h1f, d);
    end
    $display("test interrupts done");
    report_and_stop();
  end
endmodule : tb_drive_monitor_status_registers
